//--- bfop_pkg.sv
// constants, register map and field layout of the breaker failure and open pole block
package bfop_pkg;
  localparam int unsigned  BFOP_CLK_HZ        = 100_000_000;
  localparam int unsigned  BFOP_CUR_W         = 16;
  localparam int unsigned  BFOP_DLY_W         = 32;
  // current settings in units of 0.01 A
  localparam logic [15:0]  BFOP_PICKUP_RST    = 16'h0032;
  localparam logic [15:0]  BFOP_ARC_RST       = 16'h000A;
  localparam logic [15:0]  BFOP_UC_MIN        = 16'h0004;
  localparam logic [15:0]  BFOP_UC_MAX        = 16'h0050;
  localparam logic [15:0]  BFOP_UC_RST        = 16'h0004;
  // delays in milliseconds, with their reset values converted to clock cycles
  localparam int unsigned  BFOP_DELAY_MS      = 500;
  localparam int unsigned  BFOP_DROPOFF_MS    = 20;
  localparam int unsigned  BFOP_MS_CYCLES     = BFOP_CLK_HZ / 1000;
  localparam logic [31:0]  BFOP_DELAY_RST     = 32'(BFOP_DELAY_MS * BFOP_MS_CYCLES);
  localparam logic [31:0]  BFOP_DROPOFF_RST   = 32'(BFOP_DROPOFF_MS * BFOP_MS_CYCLES);
  // register byte offsets
  localparam logic [7:0]   BFOP_CTRL_OFF      = 8'h00;
  localparam logic [7:0]   BFOP_STATUS_OFF    = 8'h04;
  localparam logic [7:0]   BFOP_PU_1PH_OFF    = 8'h08;
  localparam logic [7:0]   BFOP_PU_3PH_OFF    = 8'h0C;
  localparam logic [7:0]   BFOP_PU_GND_OFF    = 8'h10;
  localparam logic [7:0]   BFOP_PU_ARC_OFF    = 8'h14;
  localparam logic [7:0]   BFOP_UC_A_OFF      = 8'h18;
  localparam logic [7:0]   BFOP_UC_B_OFF      = 8'h1C;
  localparam logic [7:0]   BFOP_UC_C_OFF      = 8'h20;
  localparam logic [7:0]   BFOP_T_1PH_OFF     = 8'h24;
  localparam logic [7:0]   BFOP_T_3PH_OFF     = 8'h28;
  localparam logic [7:0]   BFOP_T_NOLOAD_OFF  = 8'h2C;
  localparam logic [7:0]   BFOP_T_GND_OFF     = 8'h30;
  localparam logic [7:0]   BFOP_T_ARC_OFF     = 8'h34;
  localparam logic [7:0]   BFOP_T_DROP_OFF    = 8'h38;
  // control fields
  localparam int unsigned  BFOP_CTRL_BF_EN    = 0;
  localparam int unsigned  BFOP_CTRL_ARC_EN   = 1;
  localparam int unsigned  BFOP_CTRL_MODE     = 2;
  localparam int unsigned  BFOP_CTRL_CLR      = 3;
  localparam logic [3:0]   BFOP_CTRL_RST      = 4'h3;
  // status fields
  localparam int unsigned  BFOP_ST_FAIL       = 0;
  localparam int unsigned  BFOP_ST_LATCH      = 1;
  localparam int unsigned  BFOP_ST_ARC        = 2;
  localparam int unsigned  BFOP_ST_BF_EN      = 3;
  localparam int unsigned  BFOP_ST_ARC_EN     = 4;
  localparam int unsigned  BFOP_ST_POLE_A     = 5;
  localparam int unsigned  BFOP_ST_ONE        = 8;
  localparam int unsigned  BFOP_ST_ALL        = 9;
  localparam int unsigned  BFOP_ST_ANY        = 10;
  localparam int unsigned  BFOP_ST_STRAP      = 11;
  // position-input count modes
  typedef enum logic [0:0] {
    BFOP_MODE_3IN = 1'b0,
    BFOP_MODE_2IN = 1'b1
  } bfop_mode_type;
endpackage

//--- bfop_timer.sv
// pick-up delay counter that restarts whenever its condition drops
`timescale 1ns/10ps
module bfop_timer
  import bfop_pkg::*;
#(
  parameter int unsigned W = BFOP_DLY_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         sync_clr,
  input  wire logic         cond,
  input  wire logic [W-1:0] delay,
  output logic              expired
);
  logic [W-1:0] count_reg;

  if (W < 2) $error("bfop_timer width too small");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      expired   <= 1'b0;
    end else if (sync_clr || !cond) begin
      count_reg <= '0;
      expired   <= 1'b0;
    end else if (count_reg + W'(1) >= delay) begin
      expired   <= 1'b1;
    end else begin
      count_reg <= count_reg + W'(1);
    end
  end
endmodule

//--- bfop_top.sv
// breaker failure, arc detector and open pole logic with apb registers
`timescale 1ns/10ps
module bfop_top
  import bfop_pkg::*;
#(
  parameter int unsigned CUR_W = BFOP_CUR_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             sync_reset,
  input  wire logic [CUR_W-1:0] cur_a,
  input  wire logic [CUR_W-1:0] cur_b,
  input  wire logic [CUR_W-1:0] cur_c,
  input  wire logic             ext_trip_pole_a,
  input  wire logic             ext_trip_pole_b,
  input  wire logic             ext_trip_pole_c,
  input  wire logic             ext_trip_all_poles,
  input  wire logic             contact_failure_start,
  input  wire logic             ground_failure_start,
  input  wire logic             latched_failure_clear,
  input  wire logic             failure_element_enable,
  input  wire logic             arc_enable,
  input  wire logic             all_poles_open_in,
  input  wire logic             some_pole_open_in,
  input  wire logic             pole_a_nc_contact,
  input  wire logic             pole_b_nc_contact,
  input  wire logic             pole_c_nc_contact,
  output logic                  failure_flag,
  output logic                  latched_failure_flag,
  output logic                  arc_flag,
  output logic                  failure_enabled,
  output logic                  arc_enabled,
  output logic      [2:0]       pole_open,
  output logic                  single_pole_open,
  output logic                  all_poles_open,
  output logic                  any_pole_open
);
  if (CUR_W < 8 || CUR_W > 16) $error("bfop_top current width out of range");
  // two-stage synchronisers for the pin inputs
  localparam int unsigned NS = 15;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] meta_reg;
  logic [NS-1:0] pin_reg;
  assign pin_raw = {sync_reset, ext_trip_pole_a, ext_trip_pole_b, ext_trip_pole_c, ext_trip_all_poles,
                    contact_failure_start, ground_failure_start, latched_failure_clear,
                    failure_element_enable, arc_enable, all_poles_open_in, some_pole_open_in,
                    pole_a_nc_contact, pole_b_nc_contact, pole_c_nc_contact};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      pin_reg  <= '0;
    end else begin
      meta_reg <= pin_raw;
      pin_reg  <= meta_reg;
    end
  end
  logic s_srst, s_ta, s_tb, s_tc, s_t3, s_cst, s_gst, s_clr, s_bfen, s_arcen, s_and, s_or, s_na, s_nb, s_nc;
  assign {s_srst, s_ta, s_tb, s_tc, s_t3, s_cst, s_gst, s_clr, s_bfen, s_arcen, s_and, s_or,
          s_na, s_nb, s_nc} = pin_reg;

  // currents are sampled once so comparators see stable words
  logic [CUR_W-1:0] ia_reg, ib_reg, ic_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ia_reg <= '0;
      ib_reg <= '0;
      ic_reg <= '0;
    end else begin
      ia_reg <= cur_a;
      ib_reg <= cur_b;
      ic_reg <= cur_c;
    end
  end

  // software registers
  logic [3:0]  ctrl_reg;
  logic [15:0] pu_1ph_reg, pu_3ph_reg, pu_gnd_reg, pu_arc_reg;
  logic [15:0] uc_a_reg, uc_b_reg, uc_c_reg;
  logic [31:0] t_1ph_reg, t_3ph_reg, t_nl_reg, t_gnd_reg, t_arc_reg, t_drop_reg;
  logic        wr_en;
  logic        mode_strap_reg;
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;

  function automatic logic [15:0] uc_clamp(input logic [15:0] v);
    uc_clamp = (v < BFOP_UC_MIN) ? BFOP_UC_MIN : ((v > BFOP_UC_MAX) ? BFOP_UC_MAX : v);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= BFOP_CTRL_RST;
      pu_1ph_reg <= BFOP_PICKUP_RST;
      pu_3ph_reg <= BFOP_PICKUP_RST;
      pu_gnd_reg <= BFOP_PICKUP_RST;
      pu_arc_reg <= BFOP_ARC_RST;
      uc_a_reg   <= BFOP_UC_RST;
      uc_b_reg   <= BFOP_UC_RST;
      uc_c_reg   <= BFOP_UC_RST;
      t_1ph_reg  <= BFOP_DELAY_RST;
      t_3ph_reg  <= BFOP_DELAY_RST;
      t_nl_reg   <= BFOP_DELAY_RST;
      t_gnd_reg  <= BFOP_DELAY_RST;
      t_arc_reg  <= BFOP_DELAY_RST;
      t_drop_reg <= BFOP_DROPOFF_RST;
    end else begin
      ctrl_reg[BFOP_CTRL_CLR] <= 1'b0;
      if (wr_en) begin
        case (paddr)
          BFOP_CTRL_OFF:     ctrl_reg   <= pwdata[3:0];
          BFOP_PU_1PH_OFF:   pu_1ph_reg <= pwdata[15:0];
          BFOP_PU_3PH_OFF:   pu_3ph_reg <= pwdata[15:0];
          BFOP_PU_GND_OFF:   pu_gnd_reg <= pwdata[15:0];
          BFOP_PU_ARC_OFF:   pu_arc_reg <= pwdata[15:0];
          BFOP_UC_A_OFF:     uc_a_reg   <= uc_clamp(pwdata[15:0]);
          BFOP_UC_B_OFF:     uc_b_reg   <= uc_clamp(pwdata[15:0]);
          BFOP_UC_C_OFF:     uc_c_reg   <= uc_clamp(pwdata[15:0]);
          BFOP_T_1PH_OFF:    t_1ph_reg  <= pwdata;
          BFOP_T_3PH_OFF:    t_3ph_reg  <= pwdata;
          BFOP_T_NOLOAD_OFF: t_nl_reg   <= pwdata;
          BFOP_T_GND_OFF:    t_gnd_reg  <= pwdata;
          BFOP_T_ARC_OFF:    t_arc_reg  <= pwdata;
          BFOP_T_DROP_OFF:   t_drop_reg <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // status marker that reads as one once reset has been released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_strap_reg <= 1'b0;
    else          mode_strap_reg <= 1'b1;
  end

  bfop_mode_type mode;
  assign mode = bfop_mode_type'(ctrl_reg[BFOP_CTRL_MODE]);

  // enables
  assign failure_enabled = s_bfen && ctrl_reg[BFOP_CTRL_BF_EN];
  assign arc_enabled     = s_arcen && ctrl_reg[BFOP_CTRL_ARC_EN];

  // level detectors
  function automatic logic over(input logic [CUR_W-1:0] i, input logic [15:0] lvl);
    over = 16'(i) > lvl;
  endfunction
  logic oa1, ob1, oc1, any1, all3, gnd_pu;
  assign oa1    = over(ia_reg, pu_1ph_reg);
  assign ob1    = over(ib_reg, pu_1ph_reg);
  assign oc1    = over(ic_reg, pu_1ph_reg);
  assign any1   = over(ia_reg, pu_3ph_reg) || over(ib_reg, pu_3ph_reg) || over(ic_reg, pu_3ph_reg);
  assign all3   = any1;
  assign gnd_pu = over(ia_reg, pu_gnd_reg) || over(ib_reg, pu_gnd_reg) || over(ic_reg, pu_gnd_reg);

  // start conditions
  logic three_start, c_1ph, c_3ph, c_nl, c_gnd, all_open_ind;
  assign three_start  = s_t3 || (s_ta && s_tb && s_tc);
  assign c_1ph        = failure_enabled && !three_start &&
                        ((s_ta && oa1) || (s_tb && ob1) || (s_tc && oc1));
  assign c_3ph        = failure_enabled && three_start && all3;
  assign all_open_ind = s_and || (s_na && s_nb && s_nc);
  assign c_nl         = failure_enabled && s_cst && !all_open_ind;
  assign c_gnd        = failure_enabled && s_gst && gnd_pu;

  logic srst;
  assign srst = s_srst;
  logic [4:0] exp_w;
  logic [3:0] cond_w;
  logic [31:0] dly_w [5];
  assign cond_w = {c_gnd, c_nl, c_3ph, c_1ph};
  assign dly_w[0] = t_1ph_reg;
  assign dly_w[1] = t_3ph_reg;
  assign dly_w[2] = t_nl_reg;
  assign dly_w[3] = t_gnd_reg;
  assign dly_w[4] = t_arc_reg;

  // internal arc: current above arc pickup on a pole whose open contact is active
  logic c_arc;
  assign c_arc = arc_enabled && ((s_na && over(ia_reg, pu_arc_reg)) || (s_nb && over(ib_reg, pu_arc_reg)) ||
                                 (s_nc && over(ic_reg, pu_arc_reg)));

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tmr
      bfop_timer #(.W(BFOP_DLY_W)) u_tmr (
        .pclk     (pclk),
        .presetn  (presetn),
        .sync_clr (srst),
        .cond     (cond_w[g]),
        .delay    (dly_w[g]),
        .expired  (exp_w[g])
      );
    end
  endgenerate

  bfop_timer #(.W(BFOP_DLY_W)) u_arc (
    .pclk     (pclk),
    .presetn  (presetn),
    .sync_clr (srst),
    .cond     (c_arc),
    .delay    (dly_w[4]),
    .expired  (exp_w[4])
  );

  assign failure_flag = |exp_w[3:0];
  assign arc_flag     = exp_w[4];

  // latched flag: a new failure wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_failure_flag <= 1'b0;
    end else if (failure_flag) begin
      latched_failure_flag <= 1'b1;
    end else if (s_clr || ctrl_reg[BFOP_CTRL_CLR] || srst) begin
      latched_failure_flag <= 1'b0;
    end
  end

  // open pole detector
  logic uc_a, uc_b, uc_c;
  assign uc_a = !over(ia_reg, uc_a_reg);
  assign uc_b = !over(ib_reg, uc_b_reg);
  assign uc_c = !over(ic_reg, uc_c_reg);

  logic [2:0] open_next;
  logic       all_raw;
  always_comb begin
    case (mode)
      BFOP_MODE_3IN: begin
        open_next = {s_nc && uc_c, s_nb && uc_b, s_na && uc_a};
      end
      BFOP_MODE_2IN: begin
        open_next = s_and ? {uc_c, uc_b, uc_a} :
                    (s_or ? {uc_c, uc_b, uc_a} : 3'h0);
      end
      default: open_next = 3'h0;
    endcase
    all_raw = (mode == BFOP_MODE_2IN) ? (s_and && uc_a && uc_b && uc_c) : (&open_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pole_open <= 3'h0;
    else if (srst) pole_open <= 3'h0;
    else pole_open <= open_next;
  end

  // drop-off: output holds for the reset delay after the raw condition falls
  logic [31:0] drop_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_reg       <= '0;
      all_poles_open <= 1'b0;
    end else if (srst) begin
      drop_reg       <= '0;
      all_poles_open <= 1'b0;
    end else if (all_raw) begin
      drop_reg       <= '0;
      all_poles_open <= 1'b1;
    end else if (all_poles_open) begin
      if (drop_reg + 32'h1 >= t_drop_reg) begin
        all_poles_open <= 1'b0;
        drop_reg       <= '0;
      end else begin
        drop_reg <= drop_reg + 32'h1;
      end
    end
  end

  assign any_pole_open    = |pole_open;
  assign single_pole_open = any_pole_open && !all_poles_open;

  // status read
  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[BFOP_ST_FAIL]   = failure_flag;
    status_w[BFOP_ST_LATCH]  = latched_failure_flag;
    status_w[BFOP_ST_ARC]    = arc_flag;
    status_w[BFOP_ST_BF_EN]  = failure_enabled;
    status_w[BFOP_ST_ARC_EN] = arc_enabled;
    status_w[BFOP_ST_POLE_A +: 3] = pole_open;
    status_w[BFOP_ST_ONE]    = single_pole_open;
    status_w[BFOP_ST_ALL]    = all_poles_open;
    status_w[BFOP_ST_ANY]    = any_pole_open;
    status_w[BFOP_ST_STRAP]  = mode_strap_reg;
  end

  logic hit;
  always_comb begin
    hit    = 1'b1;
    prdata = '0;
    case (paddr)
      BFOP_CTRL_OFF:     prdata = {28'h0, 1'b0, ctrl_reg[2:0]};
      BFOP_STATUS_OFF:   prdata = status_w;
      BFOP_PU_1PH_OFF:   prdata = {16'h0, pu_1ph_reg};
      BFOP_PU_3PH_OFF:   prdata = {16'h0, pu_3ph_reg};
      BFOP_PU_GND_OFF:   prdata = {16'h0, pu_gnd_reg};
      BFOP_PU_ARC_OFF:   prdata = {16'h0, pu_arc_reg};
      BFOP_UC_A_OFF:     prdata = {16'h0, uc_a_reg};
      BFOP_UC_B_OFF:     prdata = {16'h0, uc_b_reg};
      BFOP_UC_C_OFF:     prdata = {16'h0, uc_c_reg};
      BFOP_T_1PH_OFF:    prdata = t_1ph_reg;
      BFOP_T_3PH_OFF:    prdata = t_3ph_reg;
      BFOP_T_NOLOAD_OFF: prdata = t_nl_reg;
      BFOP_T_GND_OFF:    prdata = t_gnd_reg;
      BFOP_T_ARC_OFF:    prdata = t_arc_reg;
      BFOP_T_DROP_OFF:   prdata = t_drop_reg;
      default:           hit    = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;
endmodule

//--- bfop_breaker_model.sv
// breaker model: auxiliary contacts and phase currents seen by the block
`timescale 1ns/10ps
module bfop_breaker_model (
  input  wire logic        pclk,
  input  wire logic [2:0]  open_cmd,
  input  wire logic        arc_cmd,
  input  wire logic [15:0] amp_a,
  input  wire logic [15:0] amp_b,
  input  wire logic [15:0] amp_c,
  output logic      [15:0] cur_a,
  output logic      [15:0] cur_b,
  output logic      [15:0] cur_c,
  output logic      [2:0]  nc_contact,
  output logic             or_contacts,
  output logic             and_contacts
);
  initial begin
    {cur_a, cur_b, cur_c} = '0;
    {nc_contact, or_contacts, and_contacts} = '0;
  end
  // an open pole carries no current unless an arc across it is modelled
  always @(posedge pclk) begin
    nc_contact   <= open_cmd;
    or_contacts  <= |open_cmd;
    and_contacts <= &open_cmd;
    cur_a        <= (open_cmd[0] && !arc_cmd) ? 16'h0000 : amp_a;
    cur_b        <= (open_cmd[1] && !arc_cmd) ? 16'h0000 : amp_b;
    cur_c        <= (open_cmd[2] && !arc_cmd) ? 16'h0000 : amp_c;
  end
endmodule

//--- bfop_monitor.sv
// assertion checker on the ports of the breaker failure and open pole block
`timescale 1ns/10ps
module bfop_monitor
  import bfop_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        sync_reset,
  input wire logic        latched_failure_clear,
  input wire logic        failure_flag,
  input wire logic        latched_failure_flag,
  input wire logic        arc_flag,
  input wire logic        failure_enabled,
  input wire logic        arc_enabled,
  input wire logic [2:0]  pole_open,
  input wire logic        single_pole_open,
  input wire logic        all_poles_open,
  input wire logic        any_pole_open
);
  logic [5:0] clr_hist_reg;
  logic [5:0] srst_hist_reg;
  logic       apb_clr;
  assign apb_clr = psel && penable && pwrite && paddr == BFOP_CTRL_OFF && pwdata[BFOP_CTRL_CLR];
  // recent causes that may legally drop the latched flag, covering the input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_hist_reg  <= '0;
      srst_hist_reg <= '0;
    end else begin
      clr_hist_reg  <= {clr_hist_reg[4:0], latched_failure_clear | sync_reset | apb_clr};
      srst_hist_reg <= {srst_hist_reg[4:0], sync_reset};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LATCH_HOLD: assert property ($fell(latched_failure_flag) |-> clr_hist_reg != 6'h00)
    else $error("latched flag dropped without a clear");
  AST_LATCH_SET: assert property (failure_flag && srst_hist_reg == 6'h00 |-> ##[0:2] latched_failure_flag)
    else $error("latched flag not set by failure");
  AST_FAIL_GATED: assert property (failure_flag |-> $past(failure_enabled))
    else $error("failure flag while element disabled");
  AST_ARC_GATED: assert property (arc_flag |-> $past(arc_enabled))
    else $error("arc flag while arc detector disabled");
  AST_ONE_POLE: assert property (single_pole_open == (|pole_open && !all_poles_open))
    else $error("one pole output mismatch");
  AST_ANY_POLE: assert property (any_pole_open == (|pole_open))
    else $error("any pole output mismatch");
  AST_DROPOFF: assert property ($past(all_poles_open) && $fell(&pole_open) && srst_hist_reg == 6'h00
    |-> all_poles_open [*2])
    else $error("all poles output dropped without delay");
  AST_UC_RANGE: assert property (psel && penable && !pwrite && paddr == BFOP_UC_A_OFF
    |-> prdata >= 32'h4 && prdata <= 32'h50)
    else $error("undercurrent level outside range");
  COV_LATCH: cover property ($fell(latched_failure_flag));
  COV_ARC: cover property ($rose(arc_flag));
  COV_DROP: cover property (all_poles_open && !(&pole_open));
endmodule
bind bfop_top bfop_monitor bfop_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .sync_reset, .latched_failure_clear, .failure_flag, .latched_failure_flag, .arc_flag,
  .failure_enabled, .arc_enabled, .pole_open, .single_pole_open, .all_poles_open, .any_pole_open);

//--- test_bfop_top.sv
// self-checking bench for the breaker failure and open pole block
`timescale 1ns/10ps
module test_bfop_top;
  import bfop_pkg::*;
  localparam int D = 10;
  logic        pclk, presetn, psel, penable, pwrite, sync_reset, pready, pslverr, slv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        ext_a, ext_b, ext_c, ext_all, cstart, gstart, lclr, fen, aen, arc_cmd;
  logic [2:0]  open_cmd, nc, pole_open, po;
  logic [15:0] amp_a, amp_b, amp_c, cur_a, cur_b, cur_c, r;
  logic        or_c, and_c, fail, latch, arc, fena, aena, one, all_o, any_o, exp_f;
  int          n_mismatch, num_checks;
  // fen, all open, low current, current mask c/b/a, then trips all/c/b/a, contact and ground starts
  int unsigned q[$] = '{12'h844, 12'hA44, 12'h8E0, 12'h8DC, 12'h802, 12'hC02, 12'h901, 12'h044};
  int unsigned p[$] = '{1, 9, 7, 6, 0};
  bfop_top bfop_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_reset(sync_reset), .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c), .ext_trip_pole_a(ext_a),
    .ext_trip_pole_b(ext_b), .ext_trip_pole_c(ext_c), .ext_trip_all_poles(ext_all),
    .contact_failure_start(cstart), .ground_failure_start(gstart), .latched_failure_clear(lclr),
    .failure_element_enable(fen), .arc_enable(aen), .all_poles_open_in(and_c), .some_pole_open_in(or_c),
    .pole_a_nc_contact(nc[0]), .pole_b_nc_contact(nc[1]), .pole_c_nc_contact(nc[2]), .failure_flag(fail),
    .latched_failure_flag(latch), .arc_flag(arc), .failure_enabled(fena), .arc_enabled(aena),
    .pole_open(pole_open), .single_pole_open(one), .all_poles_open(all_o), .any_pole_open(any_o));
  bfop_breaker_model bfop_breaker_model_inst (.pclk(pclk), .open_cmd(open_cmd), .arc_cmd(arc_cmd),
    .amp_a(amp_a), .amp_b(amp_b), .amp_c(amp_c), .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c),
    .nc_contact(nc), .or_contacts(or_c), .and_contacts(and_c));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    check(rdata, want);
  endtask
  function automatic logic pick(input int k);
    return (k == 0) ? fail : arc;
  endfunction
  // low well inside the delay, high once it has run out
  task automatic rise(input int k);
    repeat (D - 2) @(posedge pclk);
    check(pick(k), 1'b0);
    repeat (12) @(posedge pclk);
    check(pick(k), 1'b1);
  endtask
  function automatic logic fail_model();
    logic hi;
    hi = amp_a > BFOP_PICKUP_RST || amp_b > BFOP_PICKUP_RST || amp_c > BFOP_PICKUP_RST;
    return fen && ((ext_all || (ext_a && ext_b && ext_c)) && hi || ext_a && amp_a > BFOP_PICKUP_RST
      || cstart && open_cmd != 3'h7 || gstart && hi);
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, sync_reset, paddr, pwdata} = '0;
    {ext_a, ext_b, ext_c, ext_all, cstart, gstart, lclr, arc_cmd, open_cmd} = '0;
    {amp_a, amp_b, amp_c} = '0;
    {fen, aen} = 2'h3;
    void'($urandom(7022));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(BFOP_PU_1PH_OFF, 32'(BFOP_PICKUP_RST));
    rd(BFOP_PU_ARC_OFF, 32'(BFOP_ARC_RST));
    rd(BFOP_UC_B_OFF, 32'(BFOP_UC_RST));
    rd(BFOP_T_1PH_OFF, BFOP_DELAY_RST);
    rd(BFOP_T_DROP_OFF, BFOP_DROPOFF_RST);
    rd(BFOP_CTRL_OFF, 32'(BFOP_CTRL_RST));
    rd(8'h3C, 32'h0);
    check(slv, 1'b1);
    apb(1'b1, BFOP_UC_A_OFF, 32'h200);
    rd(BFOP_UC_A_OFF, 32'(BFOP_UC_MAX));
    apb(1'b1, BFOP_UC_A_OFF, 32'h1);
    rd(BFOP_UC_A_OFF, 32'(BFOP_UC_MIN));
    for (int a = 8'h24; a <= 8'h38; a += 4) apb(1'b1, 8'(a), D);
    foreach (q[i]) begin
      @(posedge pclk);
      fen      <= q[i][11];
      open_cmd <= {3{q[i][10]}};
      r = q[i][9] ? 16'h0014 : 16'($urandom_range(460, 60));
      amp_a    <= q[i][6] ? r : 16'h0000;
      amp_b    <= q[i][7] ? r : 16'h0000;
      amp_c    <= q[i][8] ? r : 16'h0000;
      {ext_all, ext_c, ext_b, ext_a, cstart, gstart} <= q[i][5:0];
      @(posedge pclk);
      exp_f = fail_model();
      if (exp_f) rise(0);
      else repeat (D + 10) @(posedge pclk);
      check(fail, exp_f);
      check(latch, exp_f);
      check(fena, q[i][11]);
      {ext_all, ext_c, ext_b, ext_a, cstart, gstart, open_cmd} <= '0;
      {amp_a, amp_b, amp_c} <= '0;
      repeat (8) @(posedge pclk);
      check(fail, 1'b0);
      check(latch, exp_f);
      if (i == 4) apb(1'b1, BFOP_CTRL_OFF, 32'(BFOP_CTRL_RST) | (32'h1 << BFOP_CTRL_CLR));
      else if (i == 6) sync_reset <= 1'b1;
      else lclr <= 1'b1;
      repeat (5) @(posedge pclk);
      sync_reset <= 1'b0;
      lclr       <= 1'b0;
      repeat (5) @(posedge pclk);
      check(latch, 1'b0);
    end
    fen <= 1'b1;
    apb(1'b1, BFOP_CTRL_OFF, 32'h2);
    @(posedge pclk);
    open_cmd <= 3'h2;
    arc_cmd  <= 1'b1;
    amp_b    <= 16'h0032;
    rise(2);
    check({fena, aena, fail}, 3'h2);
    rd(BFOP_STATUS_OFF, 32'((1 << BFOP_ST_ARC) | (1 << BFOP_ST_ARC_EN) | (1 << BFOP_ST_STRAP)));
    open_cmd <= 3'h0;
    arc_cmd  <= 1'b0;
    repeat (8) @(posedge pclk);
    check(arc, 1'b0);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, BFOP_CTRL_OFF, 32'(3 + 4 * m));
      foreach (p[j]) begin
        @(posedge pclk);
        r = 16'($urandom_range(460, 60));
        {amp_a, amp_b, amp_c} <= {3{r}};
        open_cmd <= p[j][2:0];
        arc_cmd  <= p[j][3];
        repeat (7) @(posedge pclk);
        po = p[j][3] ? 3'h0 : p[j][2:0];
        check(pole_open, po);
        check(any_o, |po);
        if (p[j] == 6) begin
          check({all_o, one}, 2'h2);
          repeat (20) @(posedge pclk);
        end
        check(all_o, po == 3'h7);
        check(one, po != 3'h0 && po != 3'h7);
      end
    end
    end_sim();
  end
endmodule
